// ===== core/csc_pkg.sv
// Purpose: Shared constants and types for the charger switch-cycle controller.
// Assumes: 125 MHz system clock; SMBus word protocol on the serial port.
// Notes: Field positions and reset values live here only.
package csc_pkg;
   // ----------------------------------------
   // Serial port
   // ----------------------------------------
   localparam logic [6:0] SLAVE_ADDR = 7'h09;    // Seven-bit bus address.
   localparam logic [7:0] CMD_CHG_AMPS = 8'h14;  // Charge-current word.
   localparam logic [7:0] CMD_CHG_VOLTS = 8'h15; // Charge-voltage word.
   localparam logic [7:0] CMD_ADAPTER = 8'h3F;   // Input-current word.
   localparam logic [7:0] CMD_MAKER = 8'hFE;     // Maker identity word.
   localparam logic [7:0] CMD_PART = 8'hFF;      // Part identity word.
   localparam logic [15:0] RST_CHG_AMPS = 16'h0000;  // Value after reset.
   localparam logic [15:0] RST_CHG_VOLTS = 16'h0000; // Value after reset.
   localparam logic [15:0] RST_ADAPTER = 16'h0080;   // Value after reset.
   localparam logic [3:0] ACK_BIT = 4'h8;        // Bit count of the ninth clock.
   // ----------------------------------------
   // Setting fields
   // ----------------------------------------
   localparam int AMPS_LSB = 7;   // Charge-current field, six bits.
   localparam int VOLTS_LSB = 4;  // Charge-voltage field, eleven bits.
   localparam int ADP_LSB = 7;    // Input-limit field, six bits of 256 mA steps.
   // ----------------------------------------
   // Switching timing
   // ----------------------------------------
   localparam int CLK_MHZ = 125;     // System clock rate.
   localparam int T_OFF_NS = 2500;   // Off-time scale, 2.5 us.
   localparam int T_MIN_NS = 300;    // Off-time floor, 0.3 us.
   localparam logic [8:0] OFF_CYC = 9'(T_OFF_NS * CLK_MHZ / 1000);
   localparam logic [8:0] MIN_CYC = 9'((T_MIN_NS * CLK_MHZ + 999) / 1000);
   localparam logic [6:0] FLOOR_NUM = 7'h58; // 88 of 100: floor ratio.
   localparam logic [6:0] FLOOR_DEN = 7'h64; // Denominator of the ratio.
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic min_level;  // Control level above the minimum threshold.
      logic peak;       // Sensed current above the control level.
      logic over_i;     // Overcurrent trip.
      logic zero_x;     // Inductor current below zero-cross threshold.
      logic over_v;     // Output overvoltage.
   } csc_cmp_t;
   typedef enum logic [2:0] {
      PH_IDLE, PH_ADDR, PH_CMD, PH_WLO, PH_WHI, PH_TXLO, PH_TXHI, PH_DONE
   } csc_phase_t;
   typedef enum logic [1:0] {SW_IDLE, SW_ON, SW_OFF} csc_sw_t;
endpackage

// ===== core/csc_top.sv
// Purpose: Serial setting port and switching-cycle sequencer of a charger.
// Assumes: SCL, SDA and comparators are asynchronous; voltage codes come
//    from a converter on clk_sys.
// Notes: The bus clock is oversampled; no logic runs on SCL itself.
// Operation
// [RL1] Slave only, answers address 0x09.
// [RL2] Only word write and word read.
// [RL3] Detect start and stop conditions.
// [RL4] SDA changes only while SCL low.
// [RL5] Eight-bit bytes sampled on SCL rise.
// [RL6] Receiver acknowledges in the ninth clock.
// [RL7] Current 0x14, voltage 0x15, reset zero.
// [RL8] Input limit 0x3F, resets to 0x0080.
// [RL9] Identity words 0xFE and 0xFF fixed.
// [RL10] Low control level holds both gates low.
// [RL11] Peak current ends on-time, low side on.
// [RL12] Overcurrent ends on-time, blocks new cycle.
// [RL13] Zero cross turns low side off.
// [RL14] Overvoltage keeps both gates off.
// [RL15] New cycle only with clean comparators.
// [RL16] Off-time scales with voltage ratio, floored.
// [RL17] Nominal 400 kHz in continuous conduction.
// [RL18] Input limit bits 7-12, 256 mA steps.
// [RL19] Zero current or voltage disables charging.
// [RL20] No charging until both words written.
// [RL21] Word low byte first, commit after both.
module csc_top
   import csc_pkg::*;
#(
   parameter int ADC_W = 10,                  // Width of the voltage codes.
   parameter logic [15:0] MAKER_ID = 16'h1234, // Arbitrary value.
   parameter logic [15:0] PART_ID = 16'h0042   // Arbitrary value.
) (
   input wire logic clk_sys,                  // System clock.
   input wire logic rst,                      // Synchronous reset.
   input wire logic ce,                       // Clock enable; low freezes all.
   input wire logic scl_in,                   // Bus clock pin level.
   input wire logic sda_in,                   // Bus data pin level.
   output logic sda_out,                      // Bus data drive level.
   output logic sda_oe,                       // High while pulling SDA.
   input wire csc_cmp_t cmp_in,               // Raw comparator outputs.
   input wire logic [ADC_W-1:0] vin_code,     // Input-side voltage code.
   input wire logic [ADC_W-1:0] vout_code,    // Output-side voltage code.
   output logic high_side_gate,               // High-side switch command.
   output logic low_side_gate,                // Low-side switch command.
   output logic charge_enable,                // Charging permitted.
   output logic [5:0] chg_amps_code,          // Charge-current field.
   output logic [10:0] chg_volts_code,        // Charge-voltage field.
   output logic [13:0] adapter_limit_ma       // Input limit in mA.
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [2:0] scl_q;          // Sync pair plus previous sample.
   logic [2:0] sda_q;          // Sync pair plus previous sample.
   csc_cmp_t cmp_m_q;          // First comparator stage.
   csc_cmp_t cmp_q;            // Second comparator stage.
   logic scl_rise;             // Bus clock rose.
   logic scl_fall;             // Bus clock fell.
   logic bus_start;            // Start or repeated start seen.
   logic bus_stop;             // Stop seen.
   csc_phase_t phase_q;        // Transaction phase.
   logic [3:0] bit_q;          // Bits taken in the current byte.
   logic [7:0] shift_q;        // Receive shifter.
   logic [7:0] tx_q;           // Transmit shifter.
   logic [7:0] cmd_q;          // Command code of this transaction.
   logic [7:0] lo_q;           // Low data byte awaiting its partner.
   logic [15:0] hi_word_q;     // Read word held; its high byte goes out later.
   logic sda_oe_q;             // Data pull-down.
   logic sda_out_q;            // Drive level, always low on an open drain.
   logic [15:0] chg_amps_limit_q;     // Charge-current word.
   logic [15:0] chg_volts_target_q;   // Charge-voltage word.
   logic [15:0] adapter_amps_limit_q; // Input-current word.
   logic amps_wr_q;            // Current word written since reset.
   logic volts_wr_q;           // Voltage word written since reset.
   logic chg_en_q;             // Charging permitted.
   logic wr_strobe;            // A full word arrived this cycle.
   logic [15:0] wr_word;       // The arrived word.
   csc_sw_t sw_q;              // Switching state.
   logic hs_q;                 // High-side command.
   logic ls_q;                 // Low-side command.
   logic [8:0] off_cnt_q;      // Cycles spent in the off-time.
   logic off_done;             // Off-time has run out.
   logic can_start;            // A new cycle may begin.

   // ----------------------------------------
   // Identity lookup
   // ----------------------------------------
   // Returns the read word for a command; every code but the two identity codes reads as zero.
   function automatic logic [15:0] read_word(input logic [7:0] code);
      case (code)
         CMD_MAKER: read_word = MAKER_ID; // [RL9]
         CMD_PART: read_word = PART_ID;   // [RL9]
         default: read_word = 16'h0000;
      endcase
   endfunction

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Two stages per pin; the third SCL and SDA stage only keeps the
   // previous settled value for edge finding.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
         cmp_m_q <= '0;
         cmp_q <= '0;
      end else if (ce) begin
         scl_q <= {scl_q[1:0], scl_in};
         sda_q <= {sda_q[1:0], sda_in};
         cmp_m_q <= cmp_in;
         cmp_q <= cmp_m_q;
      end
   end

   // Edges are judged on settled stages only.
   assign scl_rise = scl_q[1] & ~scl_q[2]; // [RL5]
   assign scl_fall = ~scl_q[1] & scl_q[2];
   // SDA moving while SCL is high marks the frame ends.
   assign bus_start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1]; // [RL3]
   assign bus_stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];  // [RL3]

   // ----------------------------------------
   // Bus byte engine
   // ----------------------------------------
   // The slave never starts traffic; it only answers inside a frame
   // that the master opened. All SDA changes happen on SCL falls.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phase_q <= PH_IDLE;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         cmd_q <= 8'h00;
         lo_q <= 8'h00;
         hi_word_q <= 16'h0000;
         sda_oe_q <= 1'b0;
      end else if (ce) begin
         if (bus_stop) begin
            // Frame closed: release the line at once.
            phase_q <= PH_IDLE; // [RL3]
            sda_oe_q <= 1'b0;
         end else if (bus_start) begin
            // A repeated start restarts the address byte.
            phase_q <= PH_ADDR; // [RL3]
            bit_q <= 4'h0;
            sda_oe_q <= 1'b0;
         end else if (phase_q != PH_IDLE && scl_rise) begin
            if (bit_q != ACK_BIT) begin
               // Data bit sampled on the rising clock.
               shift_q <= {shift_q[6:0], sda_q[1]}; // [RL5]
               bit_q <= bit_q + 4'h1;
            end else begin
               bit_q <= 4'h0;
               // In the address acknowledge the slave itself holds SDA low,
               // so only a released line marks the master's answer.
               if (phase_q == PH_TXLO && !sda_oe_q) begin
                  // Master acknowledged the low byte: send the high one.
                  if (!sda_q[1]) begin
                     phase_q <= PH_TXHI; // [RL21]
                     tx_q <= hi_word_q[15:8];
                  end else begin
                     phase_q <= PH_DONE;
                  end
               end else if (phase_q == PH_TXHI) begin
                  // The word is done whatever the master answered.
                  phase_q <= PH_DONE;
               end
            end
         end else if (phase_q != PH_IDLE && scl_fall) begin
            if (bit_q == ACK_BIT) begin
               // Byte complete: decide the ninth-clock answer.
               sda_oe_q <= 1'b0;
               case (phase_q)
                  PH_ADDR: begin
                     if (shift_q[7:1] == SLAVE_ADDR) begin // [RL1]
                        sda_oe_q <= 1'b1; // [RL6]
                        if (shift_q[0]) begin
                           // Read word: answer for the command held.
                           phase_q <= PH_TXLO; // [RL2]
                           tx_q <= 8'(read_word(cmd_q));
                           hi_word_q <= read_word(cmd_q);
                        end else begin
                           phase_q <= PH_CMD;
                        end
                     end else begin
                        // Another slave's frame; stay silent.
                        phase_q <= PH_IDLE;
                     end
                  end
                  PH_CMD: begin
                     cmd_q <= shift_q;
                     sda_oe_q <= 1'b1; // [RL6]
                     phase_q <= PH_WLO;
                  end
                  PH_WLO: begin
                     lo_q <= shift_q; // [RL21]
                     sda_oe_q <= 1'b1; // [RL6]
                     phase_q <= PH_WHI;
                  end
                  PH_WHI: begin
                     sda_oe_q <= 1'b1; // [RL6]
                     phase_q <= PH_DONE;
                  end
                  // Transmit phases release for the master's answer;
                  // extra bytes are not acknowledged.
                  default: sda_oe_q <= 1'b0;
               endcase
            end else if (phase_q == PH_TXLO || phase_q == PH_TXHI) begin
               // Next data bit goes out while SCL is low.
               sda_oe_q <= ~tx_q[7]; // [RL4]
               tx_q <= {tx_q[6:0], 1'b0};
            end else begin
               // Receiving: drop any acknowledge after the ninth clock.
               sda_oe_q <= 1'b0; // [RL4]
            end
         end
      end
   end

   // The word commits only once its high byte has landed.
   assign wr_strobe = ce && scl_fall && bit_q == ACK_BIT && phase_q == PH_WHI; // [RL21]
   assign wr_word = {shift_q, lo_q};

   // ----------------------------------------
   // Setting registers
   // ----------------------------------------
   // Write-only words; the identity words are constants and cannot be
   // written, so writes to other codes are simply dropped.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         chg_amps_limit_q <= RST_CHG_AMPS;     // [RL7]
         chg_volts_target_q <= RST_CHG_VOLTS;  // [RL7]
         adapter_amps_limit_q <= RST_ADAPTER;  // [RL8]
         amps_wr_q <= 1'b0;
         volts_wr_q <= 1'b0;
         sda_out_q <= 1'b0;
      end else if (wr_strobe) begin
         case (cmd_q)
            CMD_CHG_AMPS: begin
               chg_amps_limit_q <= wr_word; // [RL7]
               amps_wr_q <= 1'b1;           // [RL20]
            end
            CMD_CHG_VOLTS: begin
               chg_volts_target_q <= wr_word; // [RL7]
               volts_wr_q <= 1'b1;            // [RL20]
            end
            CMD_ADAPTER: adapter_amps_limit_q <= wr_word; // [RL8]
            default: sda_out_q <= 1'b0;
         endcase
      end
   end

   // Charging waits for both words and stops if either is zero.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         chg_en_q <= 1'b0;
      end else if (ce) begin
         chg_en_q <= amps_wr_q && volts_wr_q      // [RL20]
            && chg_amps_limit_q != 16'h0000       // [RL19]
            && chg_volts_target_q != 16'h0000;    // [RL19]
      end
   end

   // ----------------------------------------
   // Off-time timer
   // ----------------------------------------
   // The ratio is tested by cross multiplication rather than division:
   // count * vin >= OFF_CYC * (vin - vout). At a 0.88 ratio or above the
   // floor alone decides, which gives the minimum off-time.
   always_comb begin
      logic [ADC_W-1:0] diff;
      logic [ADC_W+8:0] lhs;
      logic [ADC_W+8:0] rhs;
      logic floor_mode;
      diff = (vin_code > vout_code) ? vin_code - vout_code : '0;
      lhs = off_cnt_q * vin_code;
      rhs = OFF_CYC * diff; // [RL17]
      floor_mode = ((ADC_W+7)'(FLOOR_DEN) * vout_code) >= ((ADC_W+7)'(FLOOR_NUM) * vin_code);
      off_done = off_cnt_q >= MIN_CYC && (floor_mode || lhs >= rhs); // [RL16]
   end

   // New cycles need a clean set of comparators and permission.
   assign can_start = chg_en_q && cmp_q.min_level && !cmp_q.over_i
      && !cmp_q.over_v; // [RL15]

   // ----------------------------------------
   // Switching sequencer
   // ----------------------------------------
   // Gates come from registers so a single faulted cycle cannot glitch
   // both switches on; they are never set together.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sw_q <= SW_IDLE;
         hs_q <= 1'b0;
         ls_q <= 1'b0;
         off_cnt_q <= 9'h000;
      end else if (ce) begin
         case (sw_q)
            SW_IDLE: begin
               hs_q <= 1'b0;
               ls_q <= 1'b0;
               if (can_start) begin
                  sw_q <= SW_ON; // [RL15]
                  hs_q <= 1'b1;
               end
            end
            SW_ON: begin
               if (!cmp_q.min_level || cmp_q.over_v || !chg_en_q) begin
                  // Low level or overvoltage: both gates off.
                  sw_q <= SW_IDLE; // [RL10] [RL14]
                  hs_q <= 1'b0;
                  ls_q <= 1'b0;
               end else if (cmp_q.peak || cmp_q.over_i) begin
                  // End on-time and start the off-time.
                  sw_q <= SW_OFF; // [RL11] [RL12]
                  hs_q <= 1'b0;
                  ls_q <= ~cmp_q.zero_x;
                  off_cnt_q <= 9'h001;
               end
            end
            SW_OFF: begin
               if (off_cnt_q != 9'h1FF) begin
                  off_cnt_q <= off_cnt_q + 9'h001;
               end
               if (!cmp_q.min_level || cmp_q.over_v) begin
                  ls_q <= 1'b0; // [RL10] [RL14]
               end else if (cmp_q.zero_x) begin
                  // Stays off until the next cycle.
                  ls_q <= 1'b0; // [RL13]
               end
               if (off_done) begin
                  sw_q <= SW_IDLE;
                  ls_q <= 1'b0;
               end
            end
            default: begin
               sw_q <= SW_IDLE;
               hs_q <= 1'b0;
               ls_q <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign sda_oe = sda_oe_q;
   assign sda_out = sda_out_q;
   assign high_side_gate = hs_q;
   assign low_side_gate = ls_q;
   assign charge_enable = chg_en_q;
   assign chg_amps_code = chg_amps_limit_q[AMPS_LSB+:6];
   assign chg_volts_code = chg_volts_target_q[VOLTS_LSB+:11];
   // Each count of the field adds one 256 mA step.
   assign adapter_limit_ma = {adapter_amps_limit_q[ADP_LSB+:6], 8'h00}; // [RL18]
endmodule

// ===== testbench/csc_top_sva.sv
// Purpose: Checker for the gate sequencer and the serial data pin.
// Assumes: Comparator pins reach the gates three clocks later.
// Notes: Bound to csc_top; sees only its ports.
module csc_top_chk
   import csc_pkg::*;
(
   input wire logic clk_sys,         // System clock.
   input wire logic rst,             // Synchronous reset.
   input wire logic ce,              // Clock enable.
   input wire logic scl_in,          // Bus clock pin.
   input wire logic sda_oe,          // Device pulls SDA.
   input wire csc_cmp_t cmp_in,      // Comparator pins.
   input wire logic high_side_gate,  // High-side command.
   input wire logic low_side_gate,   // Low-side command.
   input wire logic charge_enable    // Charging permitted.
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   // A frozen block is not judged, since no state moves then.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst || !ce);
   a_gates_never_both: assert property (!(high_side_gate && low_side_gate))
      else $error("both gates on");
   a_low_level_off: assert property (!cmp_in.min_level [*4] |->
      !high_side_gate && !low_side_gate) else $error("gates on at low level");
   a_overvolt_off: assert property (cmp_in.over_v [*4] |->
      !high_side_gate && !low_side_gate) else $error("gates on in overvoltage");
   a_overcur_off: assert property (cmp_in.over_i [*4] |-> !high_side_gate)
      else $error("high side on in overcurrent");
   a_zero_cross_off: assert property (cmp_in.zero_x [*4] |-> !low_side_gate)
      else $error("low side on below zero cross");
   a_peak_low_side: assert property ($fell(high_side_gate) && $past(charge_enable) &&
      $past(cmp_in, 3) == 5'h18 |-> low_side_gate) else $error("peak did not start off-time");
   a_start_clean: assert property ($rose(high_side_gate) |-> $past(charge_enable) &&
      $past(cmp_in.min_level, 3) && !$past(cmp_in.over_i, 3) && !$past(cmp_in.over_v, 3))
      else $error("cycle started while blocked");
   a_off_floor: assert property ($fell(high_side_gate) && low_side_gate |->
      ##36 !high_side_gate) else $error("off-time below floor");
   a_disabled_idle: assert property (!charge_enable [*2] |-> !high_side_gate)
      else $error("switching while disabled");
   a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("SDA moved while SCL high");
   a_ack_hold: assert property ($rose(sda_oe) |=> sda_oe [*8])
      else $error("SDA drive too short");
   c_peak_off: cover property ($fell(high_side_gate) && low_side_gate);
   c_ack: cover property ($rose(sda_oe));
   c_switching: cover property (charge_enable && high_side_gate);
endmodule

bind csc_top csc_top_chk u_csc_top_chk (.clk_sys(clk_sys), .rst(rst), .ce(ce),
   .scl_in(scl_in), .sda_oe(sda_oe), .cmp_in(cmp_in), .high_side_gate(high_side_gate),
   .low_side_gate(low_side_gate), .charge_enable(charge_enable));

// ===== testbench/csc_smb_master.sv
// Purpose: Bus master model issuing word writes and word reads.
// Assumes: SCL period of ten system clocks; SDA has a pull-up.
// Notes: Signals move on the falling system clock edge.
module csc_smb_master (
   input wire logic clk,       // Time base.
   input wire logic sda_line,  // Resolved SDA level.
   output logic scl,           // Bus clock, idle high.
   output logic sda_m          // Master SDA; 1 releases.
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   // ----------------------------------------
   // Bit and byte level
   // ----------------------------------------
   // SDA moves mid-low so the slave never sees it near an SCL edge.
   task automatic bitx(input logic b, output logic s);
      sda_m = b;
      wt(3);
      scl = 1'b1;
      wt(2);
      s = sda_line;
      wt(3);
      scl = 1'b0;
      wt(2);
   endtask
   task automatic start();
      sda_m = 1'b1;
      wt(3);
      scl = 1'b1;
      wt(3);
      sda_m = 1'b0;
      wt(3);
      scl = 1'b0;
      wt(2);
   endtask
   task automatic stop();
      sda_m = 1'b0;
      wt(3);
      scl = 1'b1;
      wt(3);
      sda_m = 1'b1;
      wt(5);
   endtask
   task automatic byt(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
         output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(tx[i], s);
         rx[i] = s;
      end
      bitx(mack, s);
      ack = !s;
   endtask
   // ----------------------------------------
   // Word transfers, low byte first
   // ----------------------------------------
   // A one-byte write stops early to show that half a word is dropped.
   task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
         input int nb, output logic ok);
      logic [7:0] r;
      logic k0, k1, k2, k3;
      start();
      byt({a, 1'b0}, 1'b1, r, k0);
      byt(c, 1'b1, r, k1);
      byt(d[7:0], 1'b1, r, k2);
      k3 = 1'b1;
      if (nb > 1) byt(d[15:8], 1'b1, r, k3);
      stop();
      ok = k0 & k1 & k2 & k3;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d,
         output logic ok);
      logic [7:0] r;
      logic k0, k1, k2, k3;
      start();
      byt({a, 1'b0}, 1'b1, r, k0);
      byt(c, 1'b1, r, k1);
      start();
      byt({a, 1'b1}, 1'b1, r, k2);
      byt(8'hFF, 1'b0, d[7:0], k3);
      byt(8'hFF, 1'b1, d[15:8], k3);
      stop();
      ok = k0 & k1 & k2;
   endtask
endmodule

// ===== testbench/csc_top_tb.sv
// Purpose: Self-checking bench for the charger switch-cycle controller.
// Assumes: 125 MHz clock; bus master model on SCL and SDA.
// Notes: Inputs change on the falling clock edge.
module csc_top_tb
   import csc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] MAKER = 16'hC35A; // Arbitrary value.
   localparam logic [15:0] PART = 16'h5A3C;  // Arbitrary value.
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic scl, sda_m, sda_line, sda_out, sda_oe, hs, ls, chg_en, ok;
   csc_cmp_t cmp = '0;
   logic [9:0] vin = 10'h1F4;
   logic [9:0] vout = 10'h1F4;
   logic [5:0] amps;
   logic [10:0] volts;
   logic [13:0] adp;
   logic [15:0] rdat;
   int fails = 0;
   int compares = 0;
   int cyc = 0;
   always #4 clk_sys = ~clk_sys;
   // Open-drain SDA: the pull-up wins unless someone pulls low.
   assign sda_line = sda_m & ~(sda_oe & ~sda_out);
   csc_top #(.MAKER_ID(MAKER), .PART_ID(PART)) u_csc_top (.clk_sys(clk_sys), .rst(rst),
      .ce(ce), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .cmp_in(cmp), .vin_code(vin), .vout_code(vout), .high_side_gate(hs),
      .low_side_gate(ls), .charge_enable(chg_en), .chg_amps_code(amps),
      .chg_volts_code(volts), .adapter_limit_ma(adp));
   csc_smb_master u_csc_smb_master (.clk(clk_sys), .sda_line(sda_line), .scl(scl),
      .sda_m(sda_m));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Ends one on-time by a peak, then checks the gates inside and after the off-time.
   task automatic offt(input int lo, input int hi);
      cmp.peak = 1'b1;
      wt(5);
      chk({hs, ls}, 2'b01);
      cmp.peak = 1'b0;
      wt(lo - 5);
      chk({hs, ls}, 2'b01);
      wt(hi - lo);
      chk({hs, ls}, 2'b10);
   endtask
   // A hang is cut short well above the expected run of some 4200 cycles.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         finish_test();
      end
   end
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      wt(5);
      rst = 1'b0;
      wt(3);
      chk({sda_out, sda_oe, chg_en, amps, volts}, 20'h0);
      chk(adp, 16'h0100);
      $display("test reset done");
      u_csc_smb_master.wr(SLAVE_ADDR, CMD_CHG_AMPS, 16'h1080, 2, ok);
      chk({ok, amps, chg_en}, {1'b1, 6'h21, 1'b0});
      u_csc_smb_master.wr(SLAVE_ADDR, CMD_CHG_VOLTS, 16'h41A0, 1, ok);
      chk({volts, chg_en}, 12'h0);
      u_csc_smb_master.wr(SLAVE_ADDR, CMD_CHG_VOLTS, 16'h41A0, 2, ok);
      chk({ok, volts, chg_en}, {1'b1, 11'h41A, 1'b1});
      u_csc_smb_master.wr(SLAVE_ADDR, CMD_ADAPTER, 16'hFFFF, 2, ok);
      chk(adp, 16'h3F00);
      u_csc_smb_master.wr(7'h0A, CMD_ADAPTER, 16'h0000, 2, ok);
      chk({ok, adp}, {1'b0, 14'h3F00});
      u_csc_smb_master.rd(SLAVE_ADDR, CMD_MAKER, rdat, ok);
      chk({ok, rdat}, {1'b1, MAKER});
      u_csc_smb_master.rd(SLAVE_ADDR, CMD_PART, rdat, ok);
      chk({ok, rdat}, {1'b1, PART});
      u_csc_smb_master.rd(SLAVE_ADDR, CMD_CHG_AMPS, rdat, ok);
      chk({ok, rdat}, {1'b1, 16'h0000});
      $display("test bus done");
      wt(10);
      chk({hs, ls}, 2'b00);
      cmp.min_level = 1'b1;
      wt(5);
      chk({hs, ls}, 2'b10);
      offt(25, 60);
      vin = 10'h3E8;
      offt(140, 175);
      vin = 10'h1F4;
      cmp.peak = 1'b1;
      wt(5);
      cmp.peak = 1'b0;
      cmp.zero_x = 1'b1;
      wt(5);
      chk({hs, ls}, 2'b00);
      wt(55);
      chk({hs, ls}, 2'b10);
      cmp.zero_x = 1'b0;
      cmp.over_i = 1'b1;
      wt(5);
      chk(hs, 1'b0);
      wt(60);
      chk({hs, ls}, 2'b00);
      cmp.over_i = 1'b0;
      wt(5);
      chk({hs, ls}, 2'b10);
      ce = 1'b0;
      cmp.over_v = 1'b1;
      wt(5);
      chk({hs, ls}, 2'b10);
      ce = 1'b1;
      wt(5);
      chk({hs, ls}, 2'b00);
      wt(60);
      chk({hs, ls}, 2'b00);
      cmp.over_v = 1'b0;
      cmp.min_level = 1'b0;
      wt(60);
      chk({hs, ls}, 2'b00);
      u_csc_smb_master.wr(SLAVE_ADDR, CMD_CHG_AMPS, 16'h0000, 2, ok);
      cmp.min_level = 1'b1;
      wt(20);
      chk({hs, ls, chg_en}, 3'b000);
      $display("test switching done");
      finish_test();
   end
endmodule
